// >>> core/dcc_defines.vh
// Overview of operation
// - Queue entries hold only the channel number, no parameter words.
// - Option word is read at hand-off; software waits until then.
// - Event and secondary flags readable for DMA and quick channels.
// - Completion interrupts, plus error lines per controller.
// - One completion interrupt line per shadow region, from region 0.
// - Option word holds one 6-bit code choosing the pending bit.
// - Same completion code serves final and intermediate completions.
// - Separate final and intermediate enable bits gate pending setting.
// - Enables change only through write-one set and clear registers.
// - Writing one to pending-clear low/high clears that pending bit.
// - Reevaluate bit pulses interrupt while an enabled bit is pending.
// - No new pulse while old bits pend; clear or reevaluate re-arms.
// - Region interrupt: OR of pending AND enable AND region access.
`ifndef DCC_DEFINES_VH
`define DCC_DEFINES_VH

// Register byte offsets
`define DCC_DMA_EVT_LO 12'h000
`define DCC_DMA_EVT_HI 12'h004
`define DCC_DMA_SEC_LO 12'h008
`define DCC_DMA_SEC_HI 12'h00C
`define DCC_Q_EVT 12'h010
`define DCC_Q_SEC 12'h014
`define DCC_Q_TRIG 12'h018
`define DCC_PEND_LO 12'h020
`define DCC_PEND_HI 12'h024
`define DCC_EN_LO 12'h028
`define DCC_EN_HI 12'h02C
`define DCC_PCLR_LO 12'h030
`define DCC_PCLR_HI 12'h034
`define DCC_ESET_LO 12'h038
`define DCC_ESET_HI 12'h03C
`define DCC_ECLR_LO 12'h040
`define DCC_ECLR_HI 12'h044
`define DCC_REEVAL 12'h048
`define DCC_MISS_LO 12'h04C
`define DCC_MISS_HI 12'h050
`define DCC_MISS_Q 12'h054
`define DCC_RAE_BASE 12'h060
`define DCC_OPT_BASE 12'h400

// Sizes
`define DCC_NCH 72
`define DCC_NDMA 64
`define DCC_NREG 3
`define DCC_QDEPTH 16

// Option word fields and the reevaluate bit
`define DCC_F_NOUPD 3
`define DCC_F_CODE_LSB 12
`define DCC_F_CODE_MSB 17
`define DCC_F_FIN_EN 20
`define DCC_F_INT_EN 21
`define DCC_REEVAL_BIT 0

// Reset values
`define DCC_OPT_RST 32'h0000_0000
`define DCC_RAE_RST 32'h0000_0000

`endif

// >>> core/dcc_irq_ctrl.v
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "dcc_defines.vh"

module dcc_irq_ctrl (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // Channel events, one-cycle pulses from on-chip logic
    input wire [63:0] dma_event_in,
    // Hand-off to transfer controller
    output wire xfer_req_valid,
    input wire xfer_req_ready,
    output wire [6:0] xfer_req_chan,
    output wire [31:0] xfer_req_option,
    // Completion reports from transfer controller
    input wire xfer_done_valid,
    input wire [6:0] xfer_done_chan,
    input wire xfer_done_final,
    // Transfer controller error reports
    input wire xfer_ctrl0_err_in,
    input wire xfer_ctrl1_err_in,
    // Interrupt outputs
    output reg [2:0] region_completion_irq,
    output reg channel_ctrl_error_irq,
    output reg xfer_ctrl0_error_irq,
    output reg xfer_ctrl1_error_irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg [71:0] evt_reg;
    reg [71:0] sec_reg;
    reg [71:0] miss_reg;
    reg [63:0] pend_reg;
    reg [63:0] en_reg;
    reg [63:0] rae_reg [0:2];
    reg [31:0] opt_mem [0:71];
    reg [6:0] queue_mem [0:15];
    reg [3:0] wr_ptr_reg;
    reg [3:0] rd_ptr_reg;
    reg [4:0] count_reg;
    reg [2:0] cond_prev_reg;

    // Address phase held over into the data phase
    reg ap_valid_reg;
    reg ap_write_reg;
    reg [11:0] ap_addr_reg;

    // Separate loop indices, one per process that walks an array
    integer pick_i;
    integer cond_i;
    integer cfg_i;

    // ------------------------------------------------------------
    // AHB-Lite front end
    // ------------------------------------------------------------
    // Zero wait states: the read word is captured at the address phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    wire ap_take = hsel & hready & htrans[1];
    wire wr_en = ap_valid_reg & ap_write_reg;
    wire [11:0] wa = ap_addr_reg;
    wire [11:0] ra = haddr[11:0];

    wire [6:0] opt_widx = wa[8:2];
    // Words past the last option word alias nothing: read 0, writes lost
    wire opt_wsel = (wa[11:9] == 3'b010)
        && (opt_widx < 7'd72) && (wa[1:0] == 2'b00);
    wire [6:0] opt_ridx = ra[8:2];
    wire opt_rsel = (ra[11:9] == 3'b010)
        && (opt_ridx < 7'd72);

    function [31:0] wsel;
        input [11:0] off;
        begin
            wsel = (wr_en && wa == off) ? hwdata : 32'h0000_0000;
        end
    endfunction

    wire [63:0] pclr_w = {wsel(`DCC_PCLR_HI), wsel(`DCC_PCLR_LO)};
    wire [63:0] eset_w = {wsel(`DCC_ESET_HI), wsel(`DCC_ESET_LO)};
    wire [63:0] eclr_w = {wsel(`DCC_ECLR_HI), wsel(`DCC_ECLR_LO)};
    // Only the eight quick channel bits of the third word exist
    wire [31:0] mclr_q = wsel(`DCC_MISS_Q);
    wire [71:0] mclr_w = {mclr_q[7:0], wsel(`DCC_MISS_HI),
        wsel(`DCC_MISS_LO)};
    wire [31:0] qtrig_w = wsel(`DCC_Q_TRIG);
    wire [31:0] reeval_w = wsel(`DCC_REEVAL);
    wire reeval_pulse = reeval_w[`DCC_REEVAL_BIT];

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg <= 12'h000;
        end
        else if (hready)
        begin
            ap_valid_reg <= ap_take;
            ap_write_reg <= hwrite;
            ap_addr_reg <= haddr[11:0];
        end
    end

    // ------------------------------------------------------------
    // Event capture and scheduling
    // ------------------------------------------------------------
    wire [71:0] arrive = {qtrig_w[7:0], dma_event_in};
    // Count reaches 16, one more than the four-bit pointers can hold
    wire q_full = (count_reg == 5'd16);
    wire q_empty = (count_reg == 5'd0);

    reg pick_valid;
    reg [6:0] pick_idx;

    // Lowest ready channel wins; fixed priority stands in for queue priority
    always @*
    begin
        pick_valid = 1'b0;
        pick_idx = 7'h00;
        for (pick_i = 71; pick_i >= 0; pick_i = pick_i - 1)
        begin
            if (evt_reg[pick_i] && !sec_reg[pick_i])
            begin
                pick_valid = 1'b1;
                pick_idx = pick_i[6:0];
            end
        end
    end

    wire push = pick_valid & ~q_full;
    wire pop = xfer_req_valid & xfer_req_ready;
    wire [71:0] push_mask = push ? ({71'h0, 1'b1} << pick_idx) : 72'h0;
    wire [71:0] pop_mask = pop ? ({71'h0, 1'b1} << xfer_req_chan) : 72'h0;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            evt_reg <= 72'h0;
            sec_reg <= 72'h0;
            miss_reg <= 72'h0;
        end
        else
        begin
            // New event wins over the clear caused by queueing
            evt_reg <= (evt_reg & ~push_mask) | arrive;
            sec_reg <= (sec_reg & ~pop_mask) | push_mask;
            // Event on a still-flagged channel is lost; flag it as an error
            miss_reg <= (miss_reg & ~mclr_w)
                | (arrive & evt_reg & ~push_mask);
        end
    end

    // ------------------------------------------------------------
    // Event queue: channel numbers only
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            count_reg <= 5'h00;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 4'h1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 4'h1;
            if (push && !pop)
                count_reg <= count_reg + 5'h01;
            else if (pop && !push)
                count_reg <= count_reg - 5'h01;
        end
    end

    always @(posedge hclk)
    begin
        if (push)
            queue_mem[wr_ptr_reg] <= pick_idx;
    end

    assign xfer_req_valid = ~q_empty;
    assign xfer_req_chan = q_empty ? 7'h00 : queue_mem[rd_ptr_reg];
    // Option word is fetched only now, so software edits before hand-off
    // would reach the transfer
    assign xfer_req_option = q_empty ? 32'h0000_0000
        : opt_mem[xfer_req_chan];

    // ------------------------------------------------------------
    // Parameter set option words and region access enables
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (cfg_i = 0; cfg_i < 72; cfg_i = cfg_i + 1)
                opt_mem[cfg_i] <= `DCC_OPT_RST;
            for (cfg_i = 0; cfg_i < 3; cfg_i = cfg_i + 1)
                rae_reg[cfg_i] <= {`DCC_RAE_RST, `DCC_RAE_RST};
        end
        else if (wr_en)
        begin
            if (opt_wsel)
                opt_mem[opt_widx] <= hwdata;
            for (cfg_i = 0; cfg_i < 3; cfg_i = cfg_i + 1)
            begin
                if (wa == `DCC_RAE_BASE + cfg_i[11:0] * 12'h008)
                    rae_reg[cfg_i][31:0] <= hwdata;
                if (wa == `DCC_RAE_BASE + cfg_i[11:0] * 12'h008 + 12'h004)
                    rae_reg[cfg_i][63:32] <= hwdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Completion pending and enables
    // ------------------------------------------------------------
    wire [6:0] done_idx = (xfer_done_chan < 7'd72) ? xfer_done_chan : 7'h00;
    wire [31:0] done_opt = opt_mem[done_idx];
    // One code field serves final and intermediate completions alike
    wire [5:0] done_code
        = done_opt[`DCC_F_CODE_MSB:`DCC_F_CODE_LSB];
    wire done_gate = xfer_done_final ? done_opt[`DCC_F_FIN_EN]
        : done_opt[`DCC_F_INT_EN];
    // Reports naming a channel past the last one are dropped
    wire [63:0] pend_set = (xfer_done_valid && done_gate
        && xfer_done_chan < 7'd72)
        ? ({63'h0, 1'b1} << done_code) : 64'h0;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend_reg <= 64'h0;
            en_reg <= 64'h0;
        end
        else
        begin
            // A completion in the same cycle as its clear stays pending
            pend_reg <= (pend_reg & ~pclr_w) | pend_set;
            en_reg <= (en_reg & ~eclr_w) | eset_w;
        end
    end

    // ------------------------------------------------------------
    // Interrupt outputs
    // ------------------------------------------------------------
    reg [2:0] cond;

    always @*
    begin
        // Region access enable acts as a second, per-region enable
        for (cond_i = 0; cond_i < 3; cond_i = cond_i + 1)
            cond[cond_i] = |(pend_reg & en_reg & rae_reg[cond_i]);
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cond_prev_reg <= 3'h0;
            region_completion_irq <= 3'h0;
            channel_ctrl_error_irq <= 1'b0;
            xfer_ctrl0_error_irq <= 1'b0;
            xfer_ctrl1_error_irq <= 1'b0;
        end
        else
        begin
            cond_prev_reg <= cond;
            // Pulse on a fresh rise, or on a reevaluate write while the level is high
            region_completion_irq <= (cond & ~cond_prev_reg)
                | (cond & {3{reeval_pulse}});
            channel_ctrl_error_irq <= |miss_reg;
            xfer_ctrl0_error_irq <= xfer_ctrl0_err_in;
            xfer_ctrl1_error_irq <= xfer_ctrl1_err_in;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    reg [31:0] rd_mux;

    always @*
    begin
        rd_mux = 32'h0000_0000;
        case (ra)
            `DCC_DMA_EVT_LO: rd_mux = evt_reg[31:0];
            `DCC_DMA_EVT_HI: rd_mux = evt_reg[63:32];
            `DCC_DMA_SEC_LO: rd_mux = sec_reg[31:0];
            `DCC_DMA_SEC_HI: rd_mux = sec_reg[63:32];
            `DCC_Q_EVT: rd_mux = {24'h0, evt_reg[71:64]};
            `DCC_Q_SEC: rd_mux = {24'h0, sec_reg[71:64]};
            `DCC_PEND_LO: rd_mux = pend_reg[31:0];
            `DCC_PEND_HI: rd_mux = pend_reg[63:32];
            `DCC_EN_LO: rd_mux = en_reg[31:0];
            `DCC_EN_HI: rd_mux = en_reg[63:32];
            `DCC_MISS_LO: rd_mux = miss_reg[31:0];
            `DCC_MISS_HI: rd_mux = miss_reg[63:32];
            `DCC_MISS_Q: rd_mux = {24'h0, miss_reg[71:64]};
            12'h060: rd_mux = rae_reg[0][31:0];
            12'h064: rd_mux = rae_reg[0][63:32];
            12'h068: rd_mux = rae_reg[1][31:0];
            12'h06C: rd_mux = rae_reg[1][63:32];
            12'h070: rd_mux = rae_reg[2][31:0];
            12'h074: rd_mux = rae_reg[2][63:32];
            default:
            begin
                if (opt_rsel)
                    rd_mux = opt_mem[opt_ridx];
            end
        endcase
    end

    // Sampled at the address phase, so a read right behind a write to
    // the same word returns the word as it was before that write
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (ap_take && !hwrite)
            hrdata <= rd_mux;
    end

endmodule // dcc_irq_ctrl
`default_nettype wire

// >>> verification/dcc_irq_ctrl_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module dcc_irq_ctrl_checker (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Events and hand-off
    input wire logic [63:0] dma_event_in,
    input wire logic xfer_req_valid,
    input wire logic xfer_req_ready,
    input wire logic [6:0] xfer_req_chan,
    input wire logic xfer_done_valid,
    // Error inputs and interrupts
    input wire logic xfer_ctrl0_err_in,
    input wire logic xfer_ctrl1_err_in,
    input wire logic [2:0] region_completion_irq,
    input wire logic xfer_ctrl0_error_irq,
    input wire logic xfer_ctrl1_error_irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic addr_ph;
    assign addr_ph = hsel && hready && htrans[1];

    okay_resp_a: assert property (
        hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    tc0_err_copy_a: assert property (
        xfer_ctrl0_err_in |=> xfer_ctrl0_error_irq)
        else $error("error input 0 not passed on");
    tc1_err_cause_a: assert property (
        xfer_ctrl1_error_irq |-> $past(xfer_ctrl1_err_in))
        else $error("error output 1 without cause");
    req_hold_a: assert property (
        xfer_req_valid && !xfer_req_ready
        |=> xfer_req_valid && $stable(xfer_req_chan))
        else $error("queued request lost before hand-off");
    event_req_a: assert property (
        |dma_event_in |-> ##[1:4] xfer_req_valid)
        else $error("event not offered for hand-off");
    chan_range_a: assert property (
        xfer_req_valid |-> xfer_req_chan < 7'h48)
        else $error("queued channel number out of range");
    rdata_hold_a: assert property (
        !(addr_ph && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without a read");
    irq_cause_a: assert property (
        |region_completion_irq |-> $past(xfer_done_valid, 2)
        || $past(xfer_done_valid, 3) || $past(addr_ph && hwrite, 2)
        || $past(addr_ph && hwrite, 3))
        else $error("region interrupt without cause");
    irq_single_a: assert property (
        region_completion_irq[0] |=> !region_completion_irq[0])
        else $error("region interrupt longer than one cycle");
endmodule // dcc_irq_ctrl_checker
bind dcc_irq_ctrl dcc_irq_ctrl_checker u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .dma_event_in(dma_event_in), .xfer_req_valid(xfer_req_valid),
    .xfer_req_ready(xfer_req_ready), .xfer_req_chan(xfer_req_chan),
    .xfer_done_valid(xfer_done_valid), .xfer_ctrl0_err_in(xfer_ctrl0_err_in),
    .xfer_ctrl1_err_in(xfer_ctrl1_err_in),
    .region_completion_irq(region_completion_irq),
    .xfer_ctrl0_error_irq(xfer_ctrl0_error_irq),
    .xfer_ctrl1_error_irq(xfer_ctrl1_error_irq));
`default_nettype wire

// >>> verification/dcc_xfer_model.sv
`timescale 1ns/10ps
`default_nettype none
module dcc_xfer_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bench controls
    input wire logic stall,
    input wire logic final_kind,
    input wire logic [1:0] err_req,
    // Hand-off
    input wire logic xfer_req_valid,
    output logic xfer_req_ready,
    input wire logic [6:0] xfer_req_chan,
    // Completion and errors
    output logic xfer_done_valid,
    output logic [6:0] xfer_done_chan,
    output logic xfer_done_final,
    output logic [1:0] err_out
);
    logic [1:0] busy_reg;
    // A busy engine refuses new work, so the queue really backs up
    assign xfer_req_ready = !stall && busy_reg == 2'h0;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            busy_reg <= 2'h0;
            xfer_done_valid <= 1'b0;
            xfer_done_chan <= 7'h00;
            xfer_done_final <= 1'b0;
            err_out <= 2'h0;
        end
        else
        begin
            err_out <= err_req;
            xfer_done_valid <= 1'b0;
            if (xfer_req_valid && xfer_req_ready)
            begin
                // Only the channel number arrives; its set is read now
                xfer_done_chan <= xfer_req_chan;
                busy_reg <= 2'h2;
            end
            else if (busy_reg != 2'h0)
            begin
                busy_reg <= busy_reg - 2'h1;
                xfer_done_valid <= busy_reg == 2'h1;
                xfer_done_final <= final_kind;
            end
            else
            begin
                // Idle channel field toggles between the last channel and its inverse
                xfer_done_chan <= ~xfer_done_chan;
            end
        end
    end
endmodule // dcc_xfer_model
`default_nettype wire

// >>> verification/dcc_irq_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "dcc_defines.vh"
module dcc_irq_ctrl_tb;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [63:0] dma_event_in = 64'h0;
    logic stall = 1'b0;
    logic final_kind = 1'b1;
    logic [1:0] err_req = 2'h0;
    logic [31:0] rq;
    int errors = 0;
    int checked = 0;
    int p0 = 0;
    int p1 = 0;
    wire [31:0] hrdata, xopt;
    wire hreadyout, hresp, rvalid, rready, dvalid, dfinal, cerr, terr0, terr1;
    wire [6:0] rchan, dchan;
    wire [1:0] eo;
    wire [2:0] rirq;
    dcc_irq_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .dma_event_in(dma_event_in),
        .xfer_req_valid(rvalid), .xfer_req_ready(rready),
        .xfer_req_chan(rchan), .xfer_req_option(xopt),
        .xfer_done_valid(dvalid), .xfer_done_chan(dchan),
        .xfer_done_final(dfinal), .xfer_ctrl0_err_in(eo[0]),
        .xfer_ctrl1_err_in(eo[1]), .region_completion_irq(rirq),
        .channel_ctrl_error_irq(cerr), .xfer_ctrl0_error_irq(terr0),
        .xfer_ctrl1_error_irq(terr1));
    dcc_xfer_model u_tc (.hclk(hclk), .hresetn(hresetn), .stall(stall),
        .final_kind(final_kind), .err_req(err_req), .xfer_req_valid(rvalid),
        .xfer_req_ready(rready), .xfer_req_chan(rchan),
        .xfer_done_valid(dvalid), .xfer_done_chan(dchan),
        .xfer_done_final(dfinal), .err_out(eo));
    always #12.5 hclk = ~hclk;
    always @(posedge hclk)
    begin
        p0 <= p0 + rirq[0];
        p1 <= p1 + rirq[1] + rirq[2];
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task conclude;
        begin
            if (errors == 0 && checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task chk(input string n, input logic [63:0] s, input logic [63:0] e);
        begin
            checked++;
            if (s !== e)
            begin
                errors++;
                $display("[ERR] %s expected %0h seen %0h", n, e, s);
            end
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        begin
            @(posedge hclk);
            hsel <= 1'b1;
            haddr <= {20'h0, a};
            hwrite <= w;
            htrans <= 2'h2;
            @(posedge hclk);
            while (!hreadyout) @(posedge hclk);
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge hclk);
            while (!hreadyout) @(posedge hclk);
            rq = hrdata;
        end
    endtask
    task rd(input string n, input logic [11:0] a, input logic [31:0] e);
        begin
            bus(1'b0, a, 32'h0);
            chk(n, rq, e);
        end
    endtask
    task ev(input int ch);
        begin
            @(posedge hclk);
            dma_event_in <= 64'h1 << ch;
            @(posedge hclk);
            dma_event_in <= 64'h0;
        end
    endtask
    task settle;
        int i;
        begin
            for (i = 0; i < 30 && !dvalid; i++) @(posedge hclk);
            repeat (3) @(posedge hclk);
        end
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        #500000;
        errors++;
        conclude;
    end
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rd("pending", `DCC_PEND_LO, 32'h0);
        bus(1'b1, 12'h0F0, 32'hFFFFFFFF);
        rd("unmapped", 12'h0F0, 32'h0);
        bus(1'b1, `DCC_ESET_LO, 32'h61);
        bus(1'b1, `DCC_EN_LO, 32'hFFFFFFFF);
        bus(1'b1, `DCC_ECLR_LO, 32'h1);
        rd("enable", `DCC_EN_LO, 32'h60);
        bus(1'b1, `DCC_OPT_BASE + 12'h014, 32'h00105000);
        bus(1'b1, `DCC_OPT_BASE + 12'h018, 32'h00106000);
        bus(1'b1, `DCC_RAE_BASE, 32'h60);
        stall <= 1'b1;
        ev(5);
        repeat (4) @(posedge hclk);
        chk("head", {rvalid, rchan}, 8'h85);
        chk("option", xopt, 32'h00105000);
        rd("secondary", `DCC_DMA_SEC_LO, 32'h20);
        rd("event", `DCC_DMA_EVT_LO, 32'h0);
        stall <= 1'b0;
        settle;
        rd("pending", `DCC_PEND_LO, 32'h20);
        chk("pulses", p0, 1);
        ev(6);
        settle;
        rd("pending", `DCC_PEND_LO, 32'h60);
        chk("pulses", p0, 1);
        bus(1'b1, `DCC_REEVAL, 32'h1);
        repeat (3) @(posedge hclk);
        chk("pulses", p0, 2);
        bus(1'b1, `DCC_PCLR_LO, 32'h20);
        rd("pending", `DCC_PEND_LO, 32'h40);
        bus(1'b1, `DCC_PCLR_LO, 32'h40);
        bus(1'b1, `DCC_REEVAL, 32'h1);
        repeat (3) @(posedge hclk);
        chk("pulses", p0, 2);
        final_kind <= 1'b0;
        ev(5);
        settle;
        rd("pending", `DCC_PEND_LO, 32'h0);
        bus(1'b1, `DCC_OPT_BASE + 12'h014, 32'h00205000);
        ev(5);
        settle;
        rd("pending", `DCC_PEND_LO, 32'h20);
        chk("pulses", p0, 3);
        final_kind <= 1'b1;
        // No-update bit set in the option word of quick channel 64
        bus(1'b1, `DCC_OPT_BASE + 12'h100, 32'h00107008);
        stall <= 1'b1;
        bus(1'b1, `DCC_Q_TRIG, 32'h1);
        repeat (4) @(posedge hclk);
        rd("quick sec", `DCC_Q_SEC, 32'h1);
        chk("head", {rvalid, rchan}, 8'hC0);
        stall <= 1'b0;
        settle;
        rd("quick event", `DCC_Q_EVT, 32'h0);
        rd("quick sec", `DCC_Q_SEC, 32'h0);
        rd("no-update", `DCC_OPT_BASE + 12'h100, 32'h00107008);
        rd("pending", `DCC_PEND_LO, 32'hA0);
        bus(1'b1, `DCC_RAE_BASE + 12'h008, 32'h20);
        repeat (3) @(posedge hclk);
        chk("region 1", p1, 1);
        stall <= 1'b1;
        repeat (3) ev(7);
        repeat (3) @(posedge hclk);
        chk("cc error", cerr, 1'b1);
        rd("missed", `DCC_MISS_LO, 32'h80);
        bus(1'b1, `DCC_MISS_LO, 32'h80);
        repeat (3) @(posedge hclk);
        chk("cc error", cerr, 1'b0);
        stall <= 1'b0;
        settle;
        settle;
        err_req <= 2'h3;
        repeat (3) @(posedge hclk);
        chk("tc errors", {terr1, terr0}, 2'h3);
        err_req <= 2'h0;
        chk("other regions", p1, 1);
        conclude;
    end
endmodule // dcc_irq_ctrl_tb
`default_nettype wire
